/* src/ecc_pkg.sv */
// ecc_pkg: constants, codes and the check-code function shared by the
// storage adapter files. No dependencies.
package ecc_pkg;
  localparam int DATA_W = 64;
  localparam int CHK_W = 8;
  localparam int WORD_W = 72;
  localparam int ADDR_W = 20;
  localparam logic [3:0] RETRY_LIMIT = 4'h8;
  localparam int THRESH_COUNT = 4;
  localparam int THRESH_INTERVAL = 1000000;
  localparam logic [1:0] CS_MODE_FULL = 2'h0;
  localparam logic [1:0] CS_MODE_QUIET = 2'h1;
  localparam logic [1:0] CS_MODE_THRESH = 2'h2;
  localparam logic PS_MODE_FULL = 1'b0;
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic [1:0] RES_OK = 2'h0;
  localparam logic [1:0] RES_SINGLE = 2'h1;
  localparam logic [1:0] RES_MULTI = 2'h2;

  // check bits 0..6: hamming positions over data placed at non-powers
  // of two; bit 7: overall parity of data and the seven check bits
  function automatic logic [6:0] data_pos(input int i);
    int p;
    int k;
    p = 3;
    k = 0;
    for (int j = 3; j < 128; j++) begin
      if ((j & (j - 1)) != 0) begin
        if (k == i) begin
          p = j;
        end
        k++;
      end
    end
    return p[6:0];
  endfunction

  function automatic logic [7:0] check_code(input logic [63:0] d);
    logic [7:0] c;
    logic [6:0] pos;
    c = 8'h00;
    for (int i = 0; i < DATA_W; i++) begin
      pos = data_pos(i);
      for (int b = 0; b < 7; b++) begin
        if (pos[b]) begin
          c[b] = c[b] ^ d[i];
        end
      end
    end
    c[7] = ^d ^ ^c[6:0];
    return c;
  endfunction

  function automatic logic [7:0] byte_parity(input logic [63:0] d);
    logic [7:0] p;
    p = 8'h00;
    for (int i = 0; i < 8; i++) begin
      p[i] = ~^d[i*8 +: 8];
    end
    return p;
  endfunction
endpackage

/* src/ecc_decoder.sv */
// ecc_decoder: registered check and correction of one 72-bit word.
// Assumes the caller holds chk_valid for one cycle per word.
`timescale 1ns/1ps
`default_nettype none
module ecc_decoder
  import ecc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic chk_valid,
  input wire logic [71:0] chk_word,
  output logic res_valid_q,
  output logic [1:0] res_kind_q,
  output logic [63:0] res_data_q,
  output logic [6:0] res_bit_q
);
  logic [7:0] syn;
  logic [7:0] calc;
  logic [63:0] fixed;
  logic [1:0] kind;
  logic [6:0] bitpos;

  always_comb begin
    calc = check_code(chk_word[63:0]);
    // bit 7 is parity of all 72 bits, so check-bit faults stay single
    syn = {^chk_word, calc[6:0] ^ chk_word[70:64]};
    fixed = chk_word[63:0];
    bitpos = 7'h00;
    kind = RES_OK;
    if (syn != 8'h00) begin
      if (syn[7]) begin
        // odd weight pointing nowhere is three or more bits: not fixable
        kind = RES_MULTI;
        if (syn[6:0] == 7'h00) begin
          kind = RES_SINGLE;
          bitpos = 7'h47;
        end
        for (int b = 0; b < 7; b++) begin
          if (syn[6:0] == 7'(1 << b)) begin
            kind = RES_SINGLE;
            bitpos = 7'(64 + b);
          end
        end
        for (int i = 0; i < DATA_W; i++) begin
          if (data_pos(i) == syn[6:0]) begin
            kind = RES_SINGLE;
            fixed[i] = ~fixed[i];
            bitpos = 7'(i);
          end
        end
      end else begin
        kind = RES_MULTI;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      res_valid_q <= 1'b0;
      res_kind_q <= RES_OK;
      res_data_q <= 64'h0000000000000000;
      res_bit_q <= 7'h00;
    end else begin
      res_valid_q <= chk_valid;
      if (chk_valid) begin
        res_kind_q <= kind;
        res_data_q <= fixed;
        res_bit_q <= bitpos;
      end
    end
  end
endmodule
`default_nettype wire

/* src/cs_threshold.sv */
// cs_threshold: counts control storage corrections inside a fixed interval.
// Assumes corr_pulse is a one-cycle pulse on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module cs_threshold
  import ecc_pkg::*;
#(
  parameter int COUNT = THRESH_COUNT,
  parameter int INTERVAL = THRESH_INTERVAL
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic corr_pulse,
  output logic hit_q
);
  logic [31:0] tick_q;
  logic [15:0] cnt_q;
  logic wrap;

  assign wrap = (tick_q == 32'(INTERVAL - 1));

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_q <= 32'h00000000;
    end else begin
      tick_q <= wrap ? 32'h00000000 : tick_q + 32'h00000001;
    end
  end

  // restart the count at each interval start
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 16'h0000;
      hit_q <= 1'b0;
    end else begin
      hit_q <= 1'b0;
      if (wrap) begin
        cnt_q <= 16'h0000;
      end else if (corr_pulse) begin
        if (cnt_q == 16'(COUNT - 1)) begin
          hit_q <= 1'b1;
          cnt_q <= 16'h0000;
        end else begin
          cnt_q <= cnt_q + 16'h0001;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* src/storage_ecc_with_retry.sv */
// storage_ecc_with_retry: storage adapter with ECC, storage access retry,
// CPU operation retry and machine-check reporting.
// Assumes the storage array answers a read with mem_rvalid some cycles later
// and that the CPU microprogram reports retry outcomes on op_* ports.
`timescale 1ns/1ps
`default_nettype none
module storage_ecc_with_retry
  import ecc_pkg::*;
#(
  parameter int INTERVAL = THRESH_INTERVAL,
  parameter int COUNT = THRESH_COUNT
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  // cpu side
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic cpu_cs_sel,
  input wire logic cpu_io_op,
  input wire logic [19:0] cpu_addr,
  input wire logic [63:0] cpu_wdata,
  input wire logic [7:0] cpu_wpar,
  output logic cpu_busy_q,
  output logic cpu_rvalid_q,
  output logic [63:0] cpu_rdata_q,
  output logic [7:0] cpu_rpar_q,
  output logic cpu_rerr_q,
  // storage array side
  output logic mem_req_q,
  output logic mem_we_q,
  output logic mem_cs_sel_q,
  output logic [19:0] mem_addr_q,
  output logic [71:0] mem_wdata_q,
  input wire logic mem_rvalid,
  input wire logic [71:0] mem_rdata,
  // microprogram retry hooks
  input wire logic op_fail,
  input wire logic op_done,
  input wire logic op_is_io,
  output logic op_retry_q,
  output logic op_checkpoint_q,
  // mode and mask bits
  input wire logic mode_wr,
  input wire logic [2:0] mode_wdata,
  input wire logic psw_mc_enable,
  input wire logic recovery_mask,
  output logic [2:0] mode_q,
  // machine-check reporting
  output logic mc_interrupt_q,
  output logic mc_exigent_q,
  output logic mc_repressible_q,
  output logic mc_pending_q,
  output logic io_storage_err_q,
  output logic [1:0] log_kind_q,
  output logic log_cs_q,
  output logic [19:0] log_addr_q,
  output logic [6:0] log_bit_q,
  output logic [3:0] retry_count_q
);
  // ***********************************************
  // types and local signals
  // ***********************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_READ = 3'b001,
    ST_WAIT = 3'b010,
    ST_CHECK = 3'b011,
    ST_REREAD = 3'b100,
    ST_REWRITE = 3'b101,
    ST_DONE = 3'b110
  } acc_state_e;

  acc_state_e state_q;
  logic [63:0] first_data_q;
  logic first_single_q;
  logic [6:0] first_bit_q;
  logic io_q;
  logic [63:0] wr_data_q;
  logic dec_valid;
  logic [1:0] dec_kind;
  logic [63:0] dec_data;
  logic [6:0] dec_bit;
  logic thr_hit;
  logic cs_corr_pulse;
  logic intermittent_pulse;
  logic multi_fail_pulse;
  logic retry_exhausted;
  logic op_fail_retry;
  logic report_allowed_ps;
  logic report_allowed_cs;

  // ***********************************************
  // decoder and threshold instances
  // ***********************************************
  ecc_decoder u_dec (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .chk_valid(mem_rvalid),
    .chk_word(mem_rdata),
    .res_valid_q(dec_valid),
    .res_kind_q(dec_kind),
    .res_data_q(dec_data),
    .res_bit_q(dec_bit)
  );

  cs_threshold #(
    .COUNT(COUNT),
    .INTERVAL(INTERVAL)
  ) u_thr (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .corr_pulse(cs_corr_pulse),
    .hit_q(thr_hit)
  );

  // ***********************************************
  // storage access sequencer
  // ***********************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      cpu_busy_q <= 1'b0;
      mem_req_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_cs_sel_q <= 1'b0;
      mem_addr_q <= 20'h00000;
      mem_wdata_q <= 72'h000000000000000000;
      first_single_q <= 1'b0;
      first_data_q <= 64'h0000000000000000;
      first_bit_q <= 7'h00;
      io_q <= 1'b0;
      wr_data_q <= 64'h0000000000000000;
    end else begin
      mem_req_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          cpu_busy_q <= 1'b0;
          if (cpu_req) begin
            cpu_busy_q <= 1'b1;
            mem_cs_sel_q <= cpu_cs_sel;
            mem_addr_q <= cpu_addr;
            io_q <= cpu_io_op;
            first_single_q <= 1'b0;
            mem_req_q <= 1'b1;
            mem_we_q <= cpu_we;
            // parity bits are dropped, check code appended
            mem_wdata_q <= {check_code(cpu_wdata), cpu_wdata};
            state_q <= cpu_we ? ST_DONE : ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (dec_valid) begin
            state_q <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (dec_kind == RES_SINGLE && !first_single_q) begin
            // access again to find out if the fault is solid
            first_single_q <= 1'b1;
            first_data_q <= dec_data;
            first_bit_q <= dec_bit;
            mem_req_q <= 1'b1;
            mem_we_q <= 1'b0;
            state_q <= ST_REREAD;
          end else if (first_single_q) begin
            if (mem_cs_sel_q) begin
              wr_data_q <= first_data_q;
              state_q <= ST_REWRITE;
            end else begin
              // processor storage is never written back here
              state_q <= ST_DONE;
            end
          end else begin
            state_q <= ST_DONE;
          end
        end
        ST_REREAD: begin
          if (dec_valid) begin
            state_q <= ST_CHECK;
          end
        end
        ST_REWRITE: begin
          mem_req_q <= 1'b1;
          mem_we_q <= 1'b1;
          mem_wdata_q <= {check_code(wr_data_q), wr_data_q};
          state_q <= ST_DONE;
        end
        ST_DONE: begin
          mem_we_q <= 1'b0;
          cpu_busy_q <= 1'b0;
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ***********************************************
  // fetch answer to the cpu
  // ***********************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_rvalid_q <= 1'b0;
      cpu_rdata_q <= 64'h0000000000000000;
      cpu_rpar_q <= 8'h00;
      cpu_rerr_q <= 1'b0;
    end else begin
      cpu_rvalid_q <= 1'b0;
      if (state_q == ST_CHECK && !(dec_kind == RES_SINGLE && !first_single_q))
      begin
        cpu_rvalid_q <= 1'b1;
        if (first_single_q) begin
          cpu_rdata_q <= first_data_q;
          cpu_rpar_q <= byte_parity(first_data_q);
          cpu_rerr_q <= 1'b0;
        end else begin
          cpu_rdata_q <= dec_data;
          cpu_rpar_q <= byte_parity(dec_data);
          cpu_rerr_q <= (dec_kind == RES_MULTI);
        end
      end
    end
  end

  assign intermittent_pulse = (state_q == ST_CHECK) && first_single_q &&
                              (dec_kind == RES_OK);
  assign cs_corr_pulse = intermittent_pulse && mem_cs_sel_q &&
                         (mode_q[2:1] == CS_MODE_THRESH);

  // ***********************************************
  // cpu operation retry
  // ***********************************************
  // multi-bit fetch errors outside I/O operations count as an operation failure
  assign op_fail_retry = op_fail || (cpu_rvalid_q && cpu_rerr_q && !io_q);
  assign retry_exhausted = op_fail_retry && (retry_count_q == RETRY_LIMIT);
  assign multi_fail_pulse = retry_exhausted;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      retry_count_q <= 4'h0;
      op_retry_q <= 1'b0;
      op_checkpoint_q <= 1'b0;
    end else begin
      op_retry_q <= 1'b0;
      op_checkpoint_q <= 1'b0;
      if (op_done) begin
        retry_count_q <= 4'h0;
        op_checkpoint_q <= 1'b1;
      end else if (op_fail_retry) begin
        if (retry_count_q != RETRY_LIMIT) begin
          // restart from the last checkpoint, I/O included
          retry_count_q <= retry_count_q + 4'h1;
          op_retry_q <= 1'b1;
        end else begin
          retry_count_q <= 4'h0;
        end
      end
    end
  end

  // ***********************************************
  // mode register
  // ***********************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_q <= MODE_RESET;
    end else if (thr_hit) begin
      // hardware takes over: threshold falls back to quiet
      mode_q[2:1] <= CS_MODE_QUIET;
    end else if (mode_wr) begin
      mode_q <= mode_wdata;
    end
  end

  assign report_allowed_ps = (mode_q[0] == PS_MODE_FULL);
  assign report_allowed_cs = (mode_q[2:1] == CS_MODE_FULL);

  // ***********************************************
  // machine-check reporting and logout
  // ***********************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mc_pending_q <= 1'b0;
      mc_interrupt_q <= 1'b0;
      mc_exigent_q <= 1'b0;
      mc_repressible_q <= 1'b0;
      io_storage_err_q <= 1'b0;
      log_kind_q <= RES_OK;
      log_cs_q <= 1'b0;
      log_addr_q <= 20'h00000;
      log_bit_q <= 7'h00;
    end else begin
      mc_interrupt_q <= 1'b0;
      mc_exigent_q <= 1'b0;
      mc_repressible_q <= 1'b0;
      if (intermittent_pulse && ((mem_cs_sel_q && report_allowed_cs) ||
          (!mem_cs_sel_q && report_allowed_ps))) begin
        mc_pending_q <= 1'b1;
        log_kind_q <= RES_SINGLE;
        log_cs_q <= mem_cs_sel_q;
        log_addr_q <= mem_addr_q;
        log_bit_q <= first_bit_q;
      end else if (op_done && mc_pending_q) begin
        mc_pending_q <= 1'b0;
        if (psw_mc_enable && recovery_mask) begin
          mc_interrupt_q <= 1'b1;
          mc_repressible_q <= 1'b1;
        end
      end
      if (op_done && retry_count_q != 4'h0 && psw_mc_enable &&
          recovery_mask) begin
        // retry worked: record only
        mc_interrupt_q <= 1'b1;
        mc_repressible_q <= 1'b1;
      end
      if (thr_hit && psw_mc_enable && recovery_mask) begin
        mc_interrupt_q <= 1'b1;
        mc_repressible_q <= 1'b1;
      end
      if (multi_fail_pulse) begin
        log_kind_q <= RES_MULTI;
        log_cs_q <= mem_cs_sel_q;
        log_addr_q <= mem_addr_q;
        if (psw_mc_enable) begin
          mc_interrupt_q <= 1'b1;
          mc_exigent_q <= 1'b1;
          mc_repressible_q <= 1'b0;
        end
      end
      if (cpu_rvalid_q && cpu_rerr_q && io_q && !mem_cs_sel_q) begin
        // no machine check; carried on the next I/O interruption
        io_storage_err_q <= 1'b1;
      end else if (op_done && op_is_io) begin
        io_storage_err_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* sim/storage_ecc_sva.sv */
// storage_ecc_sva: port-level checks of the storage adapter.
// Sees only the top module's ports; bound below the module.
`timescale 1ns/1ps
`default_nettype none
module storage_ecc_sva
  import ecc_pkg::*;
#(
  parameter int INTERVAL = THRESH_INTERVAL,
  parameter int COUNT = THRESH_COUNT
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic cpu_cs_sel,
  input wire logic [63:0] cpu_wdata,
  input wire logic cpu_busy_q,
  input wire logic cpu_rvalid_q,
  input wire logic [63:0] cpu_rdata_q,
  input wire logic [7:0] cpu_rpar_q,
  input wire logic cpu_rerr_q,
  input wire logic mem_req_q,
  input wire logic mem_we_q,
  input wire logic mem_cs_sel_q,
  input wire logic [71:0] mem_wdata_q,
  input wire logic mode_wr,
  input wire logic [2:0] mode_wdata,
  input wire logic psw_mc_enable,
  input wire logic [2:0] mode_q,
  input wire logic mc_interrupt_q,
  input wire logic mc_exigent_q,
  input wire logic mc_repressible_q,
  input wire logic [3:0] retry_count_q
);
  // ****
  // checks
  // ****
  function automatic logic [7:0] opar(input logic [63:0] d);
    for (int i = 0; i < 8; i++) begin
      opar[i] = ~^d[i*8 +: 8];
    end
  endfunction
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  store_format_a: assert property (
    cpu_req && cpu_we && !cpu_busy_q |=> mem_req_q && mem_we_q &&
    mem_wdata_q[63:0] == $past(cpu_wdata)) else $error("bad store");
  ps_no_rewrite_a: assert property (
    mem_req_q && mem_we_q && !mem_cs_sel_q |->
    $past(cpu_req && cpu_we && !cpu_busy_q && !cpu_cs_sel))
    else $error("processor storage rewritten");
  fetch_parity_a: assert property (
    cpu_rvalid_q && !cpu_rerr_q |-> cpu_rpar_q == opar(cpu_rdata_q))
    else $error("bad byte parity");
  rvalid_pulse_a: assert property (
    cpu_rvalid_q |=> !cpu_rvalid_q) else $error("answer too long");
  mode_write_a: assert property (
    mode_wr && mode_q[2:1] != CS_MODE_THRESH |=>
    mode_q == $past(mode_wdata)) else $error("mode not written");
  thresh_quiet_a: assert property (
    $past(reset_n) && !$past(mode_wr) &&
    $past(mode_q[2:1]) == CS_MODE_THRESH && mode_q[2:1] != CS_MODE_THRESH
    |-> mode_q[2:1] == CS_MODE_QUIET) else $error("bad fallback");
  psw_gate_a: assert property (
    mc_interrupt_q |-> $past(psw_mc_enable)) else $error("check while off");
  exigent_kind_a: assert property (
    mc_exigent_q |-> !mc_repressible_q && $past(psw_mc_enable))
    else $error("exigent misreported");
  retry_bound_a: assert property (
    retry_count_q <= RETRY_LIMIT) else $error("too many retries");
  mc_pulse_a: assert property (
    mc_interrupt_q |=> !mc_interrupt_q) else $error("check too long");
  cover property (mc_exigent_q);
  cover property (cpu_rvalid_q && cpu_rerr_q);
  cover property (mc_repressible_q);
endmodule
bind storage_ecc_with_retry storage_ecc_sva #(
  .INTERVAL(INTERVAL), .COUNT(COUNT)) u_sva (.sys_clk(sys_clk),
  .reset_n(reset_n), .cpu_req(cpu_req), .cpu_we(cpu_we),
  .cpu_cs_sel(cpu_cs_sel), .cpu_wdata(cpu_wdata), .cpu_busy_q(cpu_busy_q),
  .cpu_rvalid_q(cpu_rvalid_q), .cpu_rdata_q(cpu_rdata_q),
  .cpu_rpar_q(cpu_rpar_q), .cpu_rerr_q(cpu_rerr_q), .mem_req_q(mem_req_q),
  .mem_we_q(mem_we_q), .mem_cs_sel_q(mem_cs_sel_q),
  .mem_wdata_q(mem_wdata_q), .mode_wr(mode_wr), .mode_wdata(mode_wdata),
  .psw_mc_enable(psw_mc_enable), .mode_q(mode_q),
  .mc_interrupt_q(mc_interrupt_q), .mc_exigent_q(mc_exigent_q),
  .mc_repressible_q(mc_repressible_q), .retry_count_q(retry_count_q));
`default_nettype wire

/* sim/storage_model.sv */
// storage_model: storage array with read latency and error injection.
// Injected errors hit the next err_reads reads only.
`timescale 1ns/1ps
`default_nettype none
module storage_model
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic mem_req_q,
  input wire logic mem_we_q,
  input wire logic mem_cs_sel_q,
  input wire logic [19:0] mem_addr_q,
  input wire logic [71:0] mem_wdata_q,
  input wire logic [71:0] err_mask,
  input wire logic [3:0] err_reads,
  input wire logic err_load,
  input wire logic [3:0] extra_lat,
  output logic mem_rvalid,
  output logic [71:0] mem_rdata,
  output var int cs_writes,
  output var int ps_writes
);
  logic [71:0] mem_q [16];
  logic [71:0] word_q;
  logic [3:0] left_q;
  int wait_q;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_rvalid <= 1'h0;
      mem_rdata <= 72'h0;
      left_q <= 4'h0;
      wait_q <= 0;
      cs_writes <= 0;
      ps_writes <= 0;
    end else begin
      mem_rvalid <= 1'h0;
      // idle bus toggles so stale data never looks valid
      mem_rdata <= ~mem_rdata;
      if (err_load) begin
        left_q <= err_reads;
      end
      if (mem_req_q && mem_we_q) begin
        mem_q[mem_addr_q[3:0]] <= mem_wdata_q;
        if (mem_cs_sel_q) begin
          cs_writes <= cs_writes + 1;
        end else begin
          ps_writes <= ps_writes + 1;
        end
      end
      if (mem_req_q && !mem_we_q) begin
        word_q <= mem_q[mem_addr_q[3:0]];
        wait_q <= 2 + int'(extra_lat);
      end else if (wait_q > 0) begin
        wait_q <= wait_q - 1;
        if (wait_q == 1) begin
          mem_rvalid <= 1'h1;
          mem_rdata <= (left_q != 4'h0) ? word_q ^ err_mask : word_q;
          if (left_q != 4'h0) begin
            left_q <= left_q - 4'h1;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

/* sim/tb.sv */
// tb: self-checking bench of storage_ecc_with_retry and storage_model.
// Assumes ecc_pkg and the design are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
  $display("unexpected %s expected %0h seen %0h", nm, e, g); fails++; end end
module tb;
  import ecc_pkg::*;
  localparam logic [63:0] DW = 64'h0123456789ABCDEF;
  localparam logic [6:0] BITS [4] = '{7'h00, 7'h25, 7'h3F, 7'h40};
  logic sys_clk = 1'h0;
  logic reset_n = 1'h0;
  logic cpu_req = 1'h0, cpu_we = 1'h0, cpu_cs_sel = 1'h0, cpu_io_op = 1'h0;
  logic [19:0] cpu_addr = 20'h0;
  logic [63:0] cpu_wdata = 64'h0;
  logic [7:0] cpu_wpar = 8'h0;
  logic op_fail = 1'h0, op_done = 1'h0, op_is_io = 1'h0, mode_wr = 1'h0;
  logic [2:0] mode_wdata = 3'h0;
  logic psw_mc_enable = 1'h1, recovery_mask = 1'h1, err_load = 1'h0;
  logic [71:0] err_mask = 72'h0;
  logic [3:0] err_reads = 4'h0, extra_lat = 4'h0;
  logic cpu_busy_q, cpu_rvalid_q, cpu_rerr_q, mem_req_q, mem_we_q;
  logic mem_cs_sel_q, mem_rvalid, op_retry_q, op_checkpoint_q, log_cs_q;
  logic mc_interrupt_q, mc_exigent_q, mc_repressible_q, mc_pending_q;
  logic io_storage_err_q, rd_err;
  logic [63:0] cpu_rdata_q, rd_data;
  logic [7:0] cpu_rpar_q;
  logic [19:0] mem_addr_q, log_addr_q;
  logic [71:0] mem_wdata_q, mem_rdata, last_w;
  logic [2:0] mode_q;
  logic [1:0] log_kind_q;
  logic [6:0] log_bit_q;
  logic [3:0] retry_count_q;
  int cs_writes, ps_writes, fails = 0, n_tests = 0, cyc_n = 0;
  int n_mc = 0, n_rep = 0, n_exi = 0, n_ret = 0, n_ckp = 0;
  // short interval so the threshold window fits the run
  storage_ecc_with_retry #(.INTERVAL(3000), .COUNT(THRESH_COUNT)) dut (.*);
  storage_model u_mem (.*);
  always #10 sys_clk = ~sys_clk;
  // ****
  // monitors and tasks
  // ****
  always @(posedge sys_clk) begin
    cyc_n <= cyc_n + 1;
    if (mc_interrupt_q) n_mc <= n_mc + 1;
    if (mc_repressible_q) n_rep <= n_rep + 1;
    if (mc_exigent_q) n_exi <= n_exi + 1;
    if (op_retry_q) n_ret <= n_ret + 1;
    if (op_checkpoint_q) n_ckp <= n_ckp + 1;
    if (mem_req_q && mem_we_q) last_w <= mem_wdata_q;
    if (cpu_rvalid_q) begin
      rd_data <= cpu_rdata_q;
      rd_err <= cpu_rerr_q;
    end
    if (cyc_n == 20000) begin
      fails++;
      print_verdict();
    end
  end
  function automatic logic [7:0] opar(input logic [63:0] d);
    for (int i = 0; i < 8; i++) begin
      opar[i] = ~^d[i*8 +: 8];
    end
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic acc(input logic we, input logic cs, input logic io,
                     input logic [19:0] a);
    cpu_req <= 1'h1;
    cpu_we <= we;
    cpu_cs_sel <= cs;
    cpu_io_op <= io;
    cpu_addr <= a;
    cpu_wdata <= DW;
    cyc(1);
    cpu_req <= 1'h0;
    for (int k = 0; k < 300; k++) begin
      cyc(1);
      if (!cpu_busy_q) break;
    end
    cyc(1);
  endtask
  task automatic inj(input logic [71:0] m, input logic [3:0] n);
    err_mask <= m;
    err_reads <= n;
    err_load <= 1'h1;
    cyc(1);
    err_load <= 1'h0;
  endtask
  task automatic settle();
    int m;
    m = n_mc + n_ret + n_exi;
    for (int k = 0; k < 20 && n_mc + n_ret + n_exi == m; k++) cyc(1);
    cyc(1);
  endtask
  task automatic op(input logic f);
    op_fail <= f;
    op_done <= !f;
    cyc(1);
    op_fail <= 1'h0;
    op_done <= 1'h0;
    settle();
  endtask
  task automatic set_mode(input logic [2:0] m);
    mode_wdata <= m;
    mode_wr <= 1'h1;
    cyc(1);
    mode_wr <= 1'h0;
    cyc(1);
  endtask
  task automatic print_verdict();
    if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ****
  // scenarios
  // ****
  initial begin
    int m0, w0;
    cyc(10);
    reset_n <= 1'h1;
    cyc(1);
    `CHK("mode_q", MODE_RESET, mode_q)
    set_mode(3'h4);
    acc(1'h1, 1'h1, 1'h0, 20'h1);
    m0 = n_mc;
    w0 = cs_writes;
    for (int i = 0; i < THRESH_COUNT; i++) begin
      `CHK("cs mode", CS_MODE_THRESH, mode_q[2:1])
      inj(72'h1 << (i * 9), 4'h1);
      acc(1'h0, 1'h1, 1'h0, 20'h1);
      `CHK("cs data", DW, rd_data)
    end
    settle();
    `CHK("cs mode", CS_MODE_QUIET, mode_q[2:1])
    `CHK("threshold check", 1'h1, n_mc > m0)
    `CHK("cs rewrites", THRESH_COUNT, cs_writes - w0)
    op(1'h0);
    set_mode(3'h0);
    acc(1'h1, 1'h0, 1'h0, 20'h2);
    `CHK("stored data", DW, last_w[63:0])
    for (int s = 0; s < 2; s++) begin
      extra_lat <= s ? 4'h6 : 4'h0;
      acc(1'h0, 1'h0, 1'h0, 20'h2);
      `CHK("fetch data", DW, rd_data)
      `CHK("fetch parity", opar(DW), dut.cpu_rpar_q)
    end
    foreach (BITS[j]) begin
      w0 = ps_writes;
      m0 = n_mc;
      inj(72'h1 << BITS[j], 4'h1);
      acc(1'h0, 1'h0, 1'h0, 20'h2);
      `CHK("corrected data", DW, rd_data)
      `CHK("pending", 1'h1, mc_pending_q)
      `CHK("ps rewrites", w0, ps_writes)
      op(1'h0);
      `CHK("report", 1, n_mc - m0)
      `CHK("log bit", BITS[j], log_bit_q)
      `CHK("log place", 21'h2, {log_cs_q, log_addr_q})
      `CHK("log kind", 2'h1, log_kind_q)
    end
    inj(72'h1 << 5, 4'h2);
    acc(1'h0, 1'h0, 1'h0, 20'h2);
    `CHK("solid pending", 1'h0, mc_pending_q)
    for (int q = 0; q < 2; q++) begin
      recovery_mask <= q[0];
      set_mode(q[0] ? 3'h1 : 3'h0);
      m0 = n_mc;
      inj(72'h1 << 7, 4'h1);
      acc(1'h0, 1'h0, 1'h0, 20'h2);
      op(1'h0);
      `CHK("masked report", 0, n_mc - m0)
    end
    recovery_mask <= 1'h1;
    m0 = n_ret;
    inj(72'h3 << 10, 4'h1);
    acc(1'h0, 1'h0, 1'h0, 20'h2);
    settle();
    `CHK("multi error", 1'h1, rd_err)
    `CHK("multi retry", 1, n_ret - m0)
    op(1'h0);
    m0 = n_mc + n_ret;
    inj(72'h3 << 10, 4'h1);
    acc(1'h0, 1'h0, 1'h1, 20'h2);
    settle();
    `CHK("io error", 1'h1, io_storage_err_q)
    `CHK("io no check", 0, n_mc + n_ret - m0)
    m0 = n_ret;
    w0 = n_exi;
    repeat (8) op(1'h1);
    `CHK("retry count", RETRY_LIMIT, retry_count_q)
    op(1'h1);
    `CHK("retries", 8, n_ret - m0)
    `CHK("exigent", 1, n_exi - w0)
    `CHK("count cleared", 4'h0, retry_count_q)
    `CHK("multi log", RES_MULTI, log_kind_q)
    m0 = n_ckp;
    op(1'h0);
    `CHK("checkpoint", 1, n_ckp - m0)
    m0 = n_rep;
    op(1'h1);
    op(1'h0);
    `CHK("retry report", 1, n_rep - m0)
    psw_mc_enable <= 1'h0;
    m0 = n_mc;
    op(1'h1);
    op(1'h0);
    `CHK("psw off", 0, n_mc - m0)
    print_verdict();
  end
endmodule
`default_nettype wire
